/* design/sgp_map.vh */
`ifndef SGP_MAP_VH
`define SGP_MAP_VH
// ------------------------------------------------------------
// register layout
// ------------------------------------------------------------
`define SGP_NPINS 8
`define SGP_FUNC_LSB 0
`define SGP_FUNC_MSB 7
`define SGP_DIR_LSB 8
`define SGP_DIR_MSB 15
`define SGP_DATA_LSB 16
`define SGP_DATA_MSB 23
`define SGP_RSVD_LSB 24
`define SGP_RSVD_MSB 31
`define SGP_FUNC_RST 8'h00
`define SGP_DIR_RST 8'h00
`define SGP_DATA_RST 8'h00
// pins that own an alternate function
`define SGP_ALT_MASK 8'h3F
`define SGP_PIN_EXP_IRQ 2
`define SGP_PIN_ATTN_BTN 3
`define SGP_PIN_ATTN_IND 4
`define SGP_PIN_PWR_IND 5
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SGP_CLK_PERIOD_PS 25000
`define SGP_SAMPLE_MIN_PS 128000
// six-cycle strobe period, 150 ns, never under the 128 ns floor
`define SGP_SAMPLE_LAST 3'h5
`define SGP_CNT_W 3
`endif

/* design/sgp_sampler.v */
`timescale 1ns/1ps
`include "sgp_map.vh"
// ------------------------------------------------------------
// two-stage synchroniser with slow sample register
// ------------------------------------------------------------
module sgp_sampler (
	input wire clk_i,
	input wire rst_b_i,
	input wire [7:0] pin_async_i,
	input wire sample_en_i,
	output wire [7:0] pin_sync_o,
	output wire [7:0] pin_sampled_o
);
	reg [7:0] meta_ff;
	reg [7:0] sync_ff;
	reg [7:0] smp_ff;
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_ff <= 8'h00;
			sync_ff <= 8'h00;
			smp_ff <= `SGP_DATA_RST;
		end else begin
			meta_ff <= pin_async_i;
			sync_ff <= meta_ff;
			if (sample_en_i) begin
				smp_ff <= sync_ff;
			end
		end
	end
	assign pin_sync_o = sync_ff;
	assign pin_sampled_o = smp_ff;
endmodule

/* design/sgp_gpio.v */
`timescale 1ns/1ps
`include "sgp_map.vh"
module sgp_gpio (
	input wire clk_i,
	input wire rst_b_i,
	input wire reg_wr_i,
	input wire [31:0] reg_wdata_i,
	output wire [31:0] reg_rdata_o,
	input wire [7:0] pin_in_i,
	output wire [7:0] pin_out_o,
	output wire [7:0] pin_oe_o,
	output wire expander_irq_n_o,
	output wire upstream_attn_button_n_o,
	input wire upstream_attn_indicator_i,
	input wire upstream_power_indicator_i
);
	// ------------------------------------------------------------
	// pin modes and field helpers
	// ------------------------------------------------------------
	localparam [1:0] MODE_IN = 2'h0;
	localparam [1:0] MODE_OUT = 2'h1;
	localparam [1:0] MODE_ALT = 2'h2;
	// pins 0 and 1 handed over go quiet: their functions live outside this block
	localparam [7:0] ALT_PINS = `SGP_ALT_MASK;
	localparam [`SGP_CNT_W-1:0] SMP_LAST = `SGP_SAMPLE_LAST;

	// func bit only counts on pins that own an alternate function
	function [1:0] pin_mode;
		input func_bit;
		input dir_bit;
		input alt_ok;
		begin
			case ({func_bit & alt_ok, dir_bit})
				2'h0: pin_mode = MODE_IN;
				2'h1: pin_mode = MODE_OUT;
				default: pin_mode = MODE_ALT;
			endcase
		end
	endfunction

	// one bit per pin that is in the asked mode
	function [7:0] mode_mask;
		input [7:0] func;
		input [7:0] dir;
		input [1:0] mode;
		integer i;
		begin
			mode_mask = 8'h00;
			for (i = 0; i < `SGP_NPINS; i = i + 1) begin
				mode_mask[i] = (pin_mode(func[i], dir[i], ALT_PINS[i]) == mode);
			end
		end
	endfunction

	function [7:0] merge_bits;
		input [7:0] new_bits;
		input [7:0] old_bits;
		input [7:0] mask;
		begin
			merge_bits = (new_bits & mask) | (old_bits & ~mask);
		end
	endfunction

	// inactive level is high for both alternate inputs
	function alt_in;
		input is_alt;
		input level;
		begin
			alt_in = is_alt ? level : 1'h1;
		end
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	reg [7:0] pin_function_select_ff;
	reg [7:0] pin_direction_ff;
	reg [7:0] pin_drive_ff;
	reg [7:0] pin_out_ff;
	reg [7:0] pin_oe_ff;
	reg [`SGP_CNT_W-1:0] smp_cnt_ff;
	reg smp_en_ff;
	reg [7:0] nxt_pin_function_select;
	reg [7:0] nxt_pin_direction;
	reg [7:0] nxt_pin_drive;
	reg [7:0] nxt_pin_out;
	reg [7:0] nxt_pin_oe;
	reg [`SGP_CNT_W-1:0] nxt_smp_cnt;
	reg nxt_smp_en;
	reg [7:0] alt_out_pins;
	reg [7:0] alt_out_level;
	reg [31:0] read_word;
	wire [7:0] pin_sync;
	wire [7:0] pin_sampled;
	wire [7:0] alt_sel;
	wire [7:0] gpio_out;
	wire [7:0] pin_level_field;

	assign alt_sel = mode_mask(pin_function_select_ff, pin_direction_ff, MODE_ALT);
	assign gpio_out = mode_mask(pin_function_select_ff, pin_direction_ff, MODE_OUT);

	// ------------------------------------------------------------
	// register write
	// ------------------------------------------------------------
	always @* begin
		nxt_pin_function_select = pin_function_select_ff;
		nxt_pin_direction = pin_direction_ff;
		nxt_pin_drive = pin_drive_ff;
		if (reg_wr_i) begin
			nxt_pin_function_select = reg_wdata_i[`SGP_FUNC_MSB:`SGP_FUNC_LSB];
			nxt_pin_direction = reg_wdata_i[`SGP_DIR_MSB:`SGP_DIR_LSB];
			// mask is the output set before this write; other pins keep a level ready for a later switch
			nxt_pin_drive = merge_bits(reg_wdata_i[`SGP_DATA_MSB:`SGP_DATA_LSB], pin_drive_ff, gpio_out);
		end
	end

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_function_select_ff <= `SGP_FUNC_RST;
			pin_direction_ff <= `SGP_DIR_RST;
			pin_drive_ff <= `SGP_DATA_RST;
		end else begin
			pin_function_select_ff <= nxt_pin_function_select;
			pin_direction_ff <= nxt_pin_direction;
			pin_drive_ff <= nxt_pin_drive;
		end
	end

	// ------------------------------------------------------------
	// input sampling
	// ------------------------------------------------------------
	// strobe every sixth cycle, 150 ns: above the 128 ns floor with room for clock tolerance
	always @* begin
		if (smp_cnt_ff == SMP_LAST) begin
			nxt_smp_cnt = 3'h0;
			nxt_smp_en = 1'h1;
		end else begin
			nxt_smp_cnt = smp_cnt_ff + 3'h1;
			nxt_smp_en = 1'h0;
		end
	end

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			smp_cnt_ff <= 3'h0;
			smp_en_ff <= 1'h0;
		end else begin
			smp_cnt_ff <= nxt_smp_cnt;
			smp_en_ff <= nxt_smp_en;
		end
	end

	// pads may move at any time; only the second synchroniser stage and the slow sample register are read here
	sgp_sampler u_sampler (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.pin_async_i(pin_in_i),
		.sample_en_i(smp_en_ff),
		.pin_sync_o(pin_sync),
		.pin_sampled_o(pin_sampled)
	);

	// ------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------
	// level and enable move on the same edge; a pin switched to output drives the level stored before that write, not the data sent with it
	always @* begin
		alt_out_pins = 8'h00;
		alt_out_pins[`SGP_PIN_ATTN_IND] = alt_sel[`SGP_PIN_ATTN_IND];
		alt_out_pins[`SGP_PIN_PWR_IND] = alt_sel[`SGP_PIN_PWR_IND];
		alt_out_level = 8'h00;
		alt_out_level[`SGP_PIN_ATTN_IND] = upstream_attn_indicator_i;
		alt_out_level[`SGP_PIN_PWR_IND] = upstream_power_indicator_i;
		nxt_pin_out = merge_bits(alt_out_level, pin_drive_ff, alt_out_pins);
		nxt_pin_oe = gpio_out | alt_out_pins;
	end

	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_out_ff <= 8'h00;
			pin_oe_ff <= 8'h00;
		end else begin
			pin_out_ff <= nxt_pin_out;
			pin_oe_ff <= nxt_pin_oe;
		end
	end

	assign pin_out_o = pin_out_ff;
	assign pin_oe_o = pin_oe_ff;

	// ------------------------------------------------------------
	// alternate inputs, inactive while pin is gpio
	// ------------------------------------------------------------
	assign expander_irq_n_o = alt_in(alt_sel[`SGP_PIN_EXP_IRQ], pin_sync[`SGP_PIN_EXP_IRQ]);
	assign upstream_attn_button_n_o = alt_in(alt_sel[`SGP_PIN_ATTN_BTN], pin_sync[`SGP_PIN_ATTN_BTN]);

	// ------------------------------------------------------------
	// readback
	// ------------------------------------------------------------
	// sampled pad level, so driven and alternate pins read back as well
	assign pin_level_field = pin_sampled;

	always @* begin
		read_word = 32'h00000000;
		read_word[`SGP_FUNC_MSB:`SGP_FUNC_LSB] = pin_function_select_ff;
		read_word[`SGP_DIR_MSB:`SGP_DIR_LSB] = pin_direction_ff;
		read_word[`SGP_DATA_MSB:`SGP_DATA_LSB] = pin_level_field;
		read_word[`SGP_RSVD_MSB:`SGP_RSVD_LSB] = 8'h00;
	end

	assign reg_rdata_o = read_word;
endmodule

/* testbench/sgp_gpio_asserts.sv */
`timescale 1ns/1ps
module sgp_gpio_chk (
	input wire clk_i,
	input wire rst_b_i,
	input wire reg_wr_i,
	input wire [31:0] reg_wdata_i,
	input wire [31:0] reg_rdata_o,
	input wire [7:0] pin_in_i,
	input wire [7:0] pin_out_o,
	input wire [7:0] pin_oe_o,
	input wire expander_irq_n_o,
	input wire upstream_attn_button_n_o,
	input wire upstream_attn_indicator_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	rsvd_zero_a: assert property (reg_rdata_o[31:24] == 8'h00) else $error("rsvd");
	cfg_store_a: assert property (reg_wr_i |=> reg_rdata_o[15:0] == $past(reg_wdata_i[15:0]))
		else $error("cfg");
	// enables trail the config by one edge
	gpio_oe_a: assert property ($stable(reg_rdata_o[15:0]) |->
		((pin_oe_o ^ reg_rdata_o[15:8]) & ~reg_rdata_o[7:0]) == 8'h00) else $error("oe");
	attn_ind_a: assert property (reg_rdata_o[4] && $past(reg_rdata_o[4]) |->
		pin_oe_o[4] && pin_out_o[4] == $past(upstream_attn_indicator_i)) else $error("ind");
	irq_idle_a: assert property (!reg_rdata_o[2] && !$past(reg_rdata_o[2]) && !$past(reg_rdata_o[2], 2) |->
		expander_irq_n_o) else $error("irq");
	btn_alt_a: assert property (reg_rdata_o[3] && $past(reg_rdata_o[3], 2) |->
		upstream_attn_button_n_o == $past(pin_in_i[3], 2)) else $error("btn");
	// sync plus slow sample can trail a pad change by eight cycles
	in_read_a: assert property ($stable(pin_in_i)[*8] ##1 $stable(pin_in_i)[*2] |->
		reg_rdata_o[23:16] == pin_in_i) else $error("read");
	slow_sample_a: assert property ($changed(reg_rdata_o[23:16]) |=> $stable(reg_rdata_o[23:16])[*5])
		else $error("rate");
endmodule
bind sgp_gpio sgp_gpio_chk chk (
	.clk_i(clk_i),
	.rst_b_i(rst_b_i),
	.reg_wr_i(reg_wr_i),
	.reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o),
	.pin_in_i(pin_in_i),
	.pin_out_o(pin_out_o),
	.pin_oe_o(pin_oe_o),
	.expander_irq_n_o(expander_irq_n_o),
	.upstream_attn_button_n_o(upstream_attn_button_n_o),
	.upstream_attn_indicator_i(upstream_attn_indicator_i)
);

/* testbench/sgp_board.sv */
`timescale 1ns/1ps
// driven pads read back their own level, others follow the board
module sgp_board (
	input wire [7:0] out_i,
	input wire [7:0] oe_i,
	input wire [7:0] drv_i,
	output wire [7:0] pad_o
);
	assign pad_o = (oe_i & out_i) | (~oe_i & drv_i);
endmodule

/* testbench/sgp_gpio_tb.sv */
`timescale 1ns/1ps
`define CK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; $display("mismatch %0t got %h", $time, a); end end
module sgp_gpio_tb;
	logic clk_i = 0, rst_b_i = 0, reg_wr_i = 0;
	logic upstream_attn_indicator_i = 1, upstream_power_indicator_i = 1;
	logic [31:0] reg_wdata_i = 0;
	logic [7:0] drv = 0;
	wire [31:0] reg_rdata_o;
	wire [7:0] pin_in_i, pin_out_o, pin_oe_o;
	wire expander_irq_n_o, upstream_attn_button_n_o;
	int num_errors = 0, total_checks = 0;
	always #12.5 clk_i = ~clk_i;
	sgp_gpio uut (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.reg_wr_i(reg_wr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o),
		.pin_in_i(pin_in_i),
		.pin_out_o(pin_out_o),
		.pin_oe_o(pin_oe_o),
		.expander_irq_n_o(expander_irq_n_o),
		.upstream_attn_button_n_o(upstream_attn_button_n_o),
		.upstream_attn_indicator_i(upstream_attn_indicator_i),
		.upstream_power_indicator_i(upstream_power_indicator_i)
	);
	sgp_board pads (.out_i(pin_out_o), .oe_i(pin_oe_o), .drv_i(drv), .pad_o(pin_in_i));
	// one write, then long enough for the slow input sampler to settle
	task automatic run(input logic [31:0] w, input logic [7:0] d, input logic [31:0] er, input logic [7:0] eo);
		drv <= d;
		reg_wr_i <= 1'b1;
		reg_wdata_i <= w;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		repeat (12) @(posedge clk_i);
		`CK(reg_rdata_o, er)
		`CK(pin_oe_o, eo)
		$display("done %h", w);
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		drv <= 8'h3C;
		repeat (12) @(posedge clk_i);
		`CK(reg_rdata_o, 32'h003C0000)
		`CK(pin_oe_o, 8'h00)
		run(32'hFF5AF000, 8'h3C, 32'h000CF000, 8'hF0);
		run(32'h00A5F000, 8'h3C, 32'h00ACF000, 8'hF0);
		run(32'h0000F03C, 8'h08, 32'h0038F03C, 8'hF0);
		`CK({expander_irq_n_o, upstream_attn_button_n_o, pin_out_o[5:4]}, 4'b0111)
		run(32'h0000F000, 8'h00, 32'h0000F000, 8'hF0);
		`CK({expander_irq_n_o, upstream_attn_button_n_o}, 2'b11)
		run(32'h000000C0, 8'hC0, 32'h00C000C0, 8'h00);
		finish_test;
	end
endmodule
